// *** lpwr_cfg.svh ***
// Purpose: Constants for the low-power wait/stop controller
// Assumes: 250 MHz core clock, AXI4-Lite register access
// Notes: Register offsets are byte addresses
`ifndef LPWR_CFG_SVH
`define LPWR_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define LPWR_CTRL_OFS 4'h0
`define LPWR_STAT_OFS 4'h4
`define LPWR_CTRL_DLY_BIT 0
`define LPWR_CTRL_CONVERTER_POWER_UP_BIT 1
`define LPWR_CTRL_WDOFF_BIT 2
`define LPWR_CTRL_RST 32'h0000_0001

// ----------------------------------------
// Timing and bus response codes
// ----------------------------------------
`define LPWR_STAB_CYCLES 16'h1000
`define LPWR_RESP_OKAY 2'h0
`define LPWR_RESP_SLVERR 2'h2

`endif

// *** lpwr_pkg.sv ***
// Purpose: Types for the low-power wait/stop controller
// Assumes: Included by the controller only
// Notes: State codes are one-hot
package lpwr_pkg;
   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_STACK = 5'h02,
      ST_WAIT  = 5'h04,
      ST_STOP  = 5'h08,
      ST_STAB  = 5'h10
   } lp_state_t;
endpackage : lpwr_pkg

// *** lpwr_ctrl.sv ***
// Purpose: Wait and stop mode sequencing for the core
// Assumes: Core pulses opcode strobes for one cycle; pins are synchronous
// Notes: Osc/clock gating outputs drive the clock tree outside this block
//
// Summary of operation
// [RULE1] Idle opcode stacks registers, then waits for interrupt
// [RULE2] Oscillator runs in wait, core clock off
// [RULE3] Wait repeats reads at stacked condition-code address
// [RULE4] Any unmasked interrupt ends wait
// [RULE5] Timer gated only when global mask and watchdog_off
// [RULE6] Converter_power_up low removes converter current
// [RULE7] Stop enters when halt_block_flag clear, else no-op
// [RULE8] Stop halts every clock and oscillator
// [RULE9] Low on interrupt, nonmaskable or reset wakes
// [RULE10] Pending edge interrupt also ends stop
// [RULE11] Stop keeps state; interrupt wake resumes seamlessly
// [RULE12] Reset wake runs normal reset sequence
// [RULE13] Interrupt pin wakes only with global mask clear
// [RULE14] Nonmaskable wakes always; unmasked gets serviced
// [RULE15] Masked nonmaskable wake continues after stop
// [RULE16] Stabilisation delay on stop exit unless bypassed
// [RULE17] Every reset sets restart_delay_enable
// [RULE18] Delay on power-on reset, not warm reset
// [RULE19] With bypass, system should avoid reset wake
// [RULE20] Nonmaskable service stacks then sets both masks
// [RULE21] Delay is parameterised counter on restarted oscillator
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "lpwr_cfg.svh"

module lpwr_ctrl #(
   parameter int STAB_CYCLES = `LPWR_STAB_CYCLES,
   parameter int STACK_CYCLES = 9
) (
   // Clock and reset
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   input wire logic POR_IN,
   // Core side
   input wire logic IDLE_OPCODE_IN,
   input wire logic STOP_OPCODE_IN,
   input wire logic HALT_BLOCK_FLAG_IN,
   input wire logic GLOBAL_MASK_IN,
   input wire logic NMI_MASK_IN,
   input wire logic [15:0] CCR_STACK_ADDR_IN,
   input wire logic INT_PENDING_IN,
   input wire logic IRQ_EDGE_PENDING_IN,
   // Pins
   input wire logic IRQ_N_IN,
   input wire logic NMI_REQ_N_IN,
   // Core controls
   output logic CORE_CLK_EN_OUT,
   output logic OSC_EN_OUT,
   output logic TIMER_CLK_EN_OUT,
   output logic ADC_PWR_OUT,
   output logic STACK_REQ_OUT,
   output logic BUS_READ_OUT,
   output logic [15:0] BUS_ADDR_OUT,
   output logic NMI_SERVICE_OUT,
   output logic SET_MASKS_OUT,
   output logic RESUME_OUT,
   output logic CPU_RESET_OUT,
   // AXI4-Lite slave
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);

   initial begin
      if (STAB_CYCLES < 1 || STAB_CYCLES > 65535 || STACK_CYCLES < 1 || STACK_CYCLES > 255)
         $error("lpwr_ctrl: unsupported parameter");
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   lpwr_pkg::lp_state_t state_ff, nxt_state;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [2:0] ctrl_ff;
   logic nmi_svc_ff, nxt_nmi_svc;
   logic resume_ff, nxt_resume;
   logic warm_ff;
   logic aw_ff, w_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;

   // ----------------------------------------
   // Wake decode
   // ----------------------------------------
   wire logic dly_en = ctrl_ff[`LPWR_CTRL_DLY_BIT];
   wire logic irq_wake = (!IRQ_N_IN || IRQ_EDGE_PENDING_IN) && !GLOBAL_MASK_IN; // RULE10 RULE13
   wire logic nmi_low = !NMI_REQ_N_IN;
   wire logic stop_wake = irq_wake || nmi_low; // RULE9
   wire logic wait_wake = INT_PENDING_IN || (nmi_low && !NMI_MASK_IN) || irq_wake; // RULE4
   wire logic stop_go = STOP_OPCODE_IN && !HALT_BLOCK_FLAG_IN; // RULE7
   wire logic in_wait = (state_ff == lpwr_pkg::ST_WAIT);
   wire logic in_stop = (state_ff == lpwr_pkg::ST_STOP);

   // ----------------------------------------
   // Mode sequencer
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_nmi_svc = nmi_svc_ff;
      nxt_resume = 1'b0;
      case (state_ff)
         lpwr_pkg::ST_RUN: begin
            if (IDLE_OPCODE_IN) begin
               nxt_state = lpwr_pkg::ST_STACK; // RULE1
               nxt_cnt = 16'(STACK_CYCLES);
            end else if (stop_go) begin
               nxt_state = lpwr_pkg::ST_STOP; // RULE8
            end
         end
         lpwr_pkg::ST_STACK: begin
            if (cnt_ff <= 16'h0001) nxt_state = lpwr_pkg::ST_WAIT;
            else nxt_cnt = cnt_ff - 16'h0001;
         end
         lpwr_pkg::ST_WAIT: begin
            if (wait_wake) begin
               nxt_state = lpwr_pkg::ST_RUN; // RULE4
               nxt_resume = 1'b1;
            end
         end
         lpwr_pkg::ST_STOP: begin
            if (stop_wake) begin
               // Unmasked nonmaskable gets stacked service, masked one just resumes
               nxt_nmi_svc = nmi_low && !NMI_MASK_IN; // RULE14 RULE15
               nxt_state = dly_en ? lpwr_pkg::ST_STAB : lpwr_pkg::ST_RUN; // RULE16
               nxt_cnt = 16'(STAB_CYCLES);
               nxt_resume = !dly_en;
            end
         end
         lpwr_pkg::ST_STAB: begin
            // Counts on the restarted oscillator clock
            if (cnt_ff <= 16'h0001) begin
               nxt_state = lpwr_pkg::ST_RUN; // RULE21
               nxt_resume = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 16'h0001;
            end
         end
         default: nxt_state = lpwr_pkg::ST_RUN;
      endcase
      if (state_ff == lpwr_pkg::ST_RUN && nmi_svc_ff) nxt_nmi_svc = 1'b0;
   end

   // Power-on enters the stabilisation wait; a warm reset does not
   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_ff <= lpwr_pkg::ST_RUN;
         cnt_ff <= 16'h0000;
         nmi_svc_ff <= 1'b0;
         resume_ff <= 1'b0;
         warm_ff <= 1'b0;
      end else if (!warm_ff) begin
         warm_ff <= 1'b1;
         state_ff <= POR_IN ? lpwr_pkg::ST_STAB : lpwr_pkg::ST_RUN; // RULE18
         cnt_ff <= 16'(STAB_CYCLES);
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         nmi_svc_ff <= nxt_nmi_svc;
         resume_ff <= nxt_resume;
      end
   end

   // ----------------------------------------
   // Clock, power and core controls
   // ----------------------------------------
   // Core state is simply frozen by the gated clock, so resume is seamless
   assign CORE_CLK_EN_OUT = (state_ff == lpwr_pkg::ST_RUN) || (state_ff == lpwr_pkg::ST_STACK); // RULE2 RULE11
   assign OSC_EN_OUT = !in_stop; // RULE2 RULE8
   assign TIMER_CLK_EN_OUT = !in_stop && !(in_wait && GLOBAL_MASK_IN && ctrl_ff[`LPWR_CTRL_WDOFF_BIT]); // RULE5
   assign ADC_PWR_OUT = ctrl_ff[`LPWR_CTRL_CONVERTER_POWER_UP_BIT] && !in_stop; // RULE6
   assign STACK_REQ_OUT = (state_ff == lpwr_pkg::ST_STACK); // RULE1
   assign BUS_READ_OUT = in_wait; // RULE3
   assign BUS_ADDR_OUT = in_wait ? CCR_STACK_ADDR_IN : 16'h0000; // RULE3
   assign NMI_SERVICE_OUT = nmi_svc_ff && state_ff == lpwr_pkg::ST_RUN; // RULE14
   assign SET_MASKS_OUT = NMI_SERVICE_OUT; // RULE20
   assign RESUME_OUT = resume_ff;
   assign CPU_RESET_OUT = !warm_ff; // RULE12

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   wire logic wr_go = aw_ff && w_ff && !bvalid_ff;
   wire logic wr_ctrl = (awaddr_ff == `LPWR_CTRL_OFS);
   wire logic wr_stat = (awaddr_ff == `LPWR_STAT_OFS);
   wire logic rd_ctrl = (S_AXI_ARADDR == `LPWR_CTRL_OFS);
   wire logic rd_stat = (S_AXI_ARADDR == `LPWR_STAT_OFS);
   wire logic [31:0] stat_word = {26'h0, nmi_svc_ff, state_ff};
   assign S_AXI_AWREADY = !aw_ff;
   assign S_AXI_WREADY = !w_ff;
   assign S_AXI_ARREADY = !rvalid_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;

   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && !aw_ff) begin
            aw_ff <= 1'b1;
            awaddr_ff <= S_AXI_AWADDR;
         end else if (wr_go) begin
            aw_ff <= 1'b0;
         end
         if (S_AXI_WVALID && !w_ff) begin
            w_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ctrl_ff <= 3'(`LPWR_CTRL_RST); // RULE17
         bvalid_ff <= 1'b0;
         bresp_ff <= `LPWR_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= `LPWR_RESP_OKAY;
         rdata_ff <= 32'h0;
      end else begin
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_ctrl || wr_stat) ? `LPWR_RESP_OKAY : `LPWR_RESP_SLVERR;
            if (wr_ctrl && wstrb_ff[0]) ctrl_ff <= wdata_ff[2:0];
         end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
         end
         if (S_AXI_ARVALID && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_ctrl ? {29'h0, ctrl_ff} : (rd_stat ? stat_word : 32'h0);
            rresp_ff <= (rd_ctrl || rd_stat) ? `LPWR_RESP_OKAY : `LPWR_RESP_SLVERR;
         end else if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_STACK_FIRST: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (warm_ff && state_ff == lpwr_pkg::ST_RUN && IDLE_OPCODE_IN) |=> STACK_REQ_OUT) // RULE1
      else $error("idle opcode did not start stacking");
   AST_OSC_WAIT: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      in_wait |-> (OSC_EN_OUT && !CORE_CLK_EN_OUT)) // RULE2
      else $error("wait clocking wrong");
   AST_WAIT_READ: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      in_wait |-> (BUS_READ_OUT && BUS_ADDR_OUT == CCR_STACK_ADDR_IN)) // RULE3
      else $error("wait bus read missing");
   AST_WAIT_EXIT: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_wait && INT_PENDING_IN) |=> (state_ff == lpwr_pkg::ST_RUN && RESUME_OUT)) // RULE4
      else $error("wait not left on interrupt");
   AST_TIMER_GATE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_wait && !GLOBAL_MASK_IN) |-> TIMER_CLK_EN_OUT) // RULE5
      else $error("timer gated with mask clear");
   AST_STOP_NOP: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (warm_ff && state_ff == lpwr_pkg::ST_RUN && STOP_OPCODE_IN && HALT_BLOCK_FLAG_IN
       && !IDLE_OPCODE_IN) |=> state_ff == lpwr_pkg::ST_RUN) // RULE7
      else $error("blocked stop entered stop");
   AST_STOP_CLK: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      in_stop |-> !(OSC_EN_OUT || CORE_CLK_EN_OUT || TIMER_CLK_EN_OUT)) // RULE8
      else $error("clock running in stop");
   AST_IRQ_MASKED: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && GLOBAL_MASK_IN && NMI_REQ_N_IN) |=> in_stop) // RULE13
      else $error("masked interrupt woke stop");
   AST_NMI_MASKED: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && !NMI_REQ_N_IN && NMI_MASK_IN) |=> !nmi_svc_ff) // RULE15
      else $error("masked nonmaskable serviced");
   AST_STAB_LEN: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && stop_wake && dly_en) |=> (state_ff == lpwr_pkg::ST_STAB)[*8]) // RULE16
      else $error("stabilisation delay too short");

   AST_ADC_WAIT: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_wait && !ctrl_ff[`LPWR_CTRL_CONVERTER_POWER_UP_BIT]) |-> !ADC_PWR_OUT) // RULE6
      else $error("converter powered while off");
   AST_EDGE_WAKE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && IRQ_EDGE_PENDING_IN && !GLOBAL_MASK_IN) |=> !in_stop) // RULE10
      else $error("pending edge did not end stop");
   AST_STOP_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && IRQ_N_IN && NMI_REQ_N_IN && !IRQ_EDGE_PENDING_IN) |=> in_stop) // RULE11
      else $error("stop left without wake");
   AST_RESET_SEQ: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      !warm_ff |-> (CPU_RESET_OUT && state_ff == lpwr_pkg::ST_RUN)) // RULE12
      else $error("reset sequence not run");
   AST_DLY_SET: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      !warm_ff |-> dly_en) // RULE17
      else $error("delay enable not set by reset");
   AST_POR_STAB: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (!warm_ff && POR_IN) |=> state_ff == lpwr_pkg::ST_STAB) // RULE18
      else $error("power-on skipped stabilisation");
   AST_NMI_SVC: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && !NMI_REQ_N_IN && !NMI_MASK_IN) |=> nmi_svc_ff) // RULE14
      else $error("unmasked nonmaskable not serviced");
   AST_BYPASS: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      (in_stop && stop_wake && !dly_en) |=> (state_ff == lpwr_pkg::ST_RUN && RESUME_OUT)) // RULE16
      else $error("bypassed delay still waited");
   AST_SVC_ONCE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      NMI_SERVICE_OUT |=> !NMI_SERVICE_OUT) // RULE20
      else $error("service request repeated");

   // ----------------------------------------
   // Coverage of the main sequences
   // ----------------------------------------
   COV_WAIT: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) in_wait ##1 RESUME_OUT);
   COV_POR: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      !warm_ff && POR_IN ##1 state_ff == lpwr_pkg::ST_STAB);
   COV_STOP_NMI: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      in_stop ##1 nmi_svc_ff);
   COV_STOP_FAST: cover property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
      in_stop && !dly_en ##1 RESUME_OUT);

endmodule : lpwr_ctrl
`default_nettype wire

// *** core_pins_model.sv ***
// Purpose: Core and wake-pin model beside the low-power controller
// Assumes: Tasks are called just after a rising clock edge
// Notes: Wake pins rest high as if pulled up
`timescale 1ns/100ps
`default_nettype none
module core_pins_model (
   // Clock and controller feedback
   input wire logic clk_in,
   input wire logic masks_in,
   // Core and pins
   output logic idle_out,
   output logic stop_out,
   output logic halt_out,
   output logic gm_out,
   output logic nm_out,
   output logic [15:0] addr_out,
   output logic ip_out,
   output logic ep_out,
   output logic irq_n_out,
   output logic nmi_n_out
);
   initial begin
      {idle_out, stop_out, halt_out, ip_out, ep_out} = 5'h00;
      {gm_out, nm_out, irq_n_out, nmi_n_out} = 4'hF;
      addr_out = 16'h01F7;
   end
   // Core masks further requests after stacking for service
   always @(posedge clk_in) begin
      if (masks_in === 1'b1) begin
         gm_out <= 1'b1;
         nm_out <= 1'b1;
      end
   end
   task automatic op(input logic is_stop);
      idle_out <= !is_stop;
      stop_out <= is_stop;
      @(posedge clk_in);
      idle_out <= 1'b0;
      stop_out <= 1'b0;
   endtask : op
   task automatic flags(input logic halt, input logic gm, input logic nm);
      halt_out <= halt;
      gm_out <= gm;
      nm_out <= nm;
   endtask : flags
   // Wakes by pins or pending flags, held briefly then released to rest level
   task automatic wake(input int src);
      case (src)
         0: irq_n_out <= 1'b0;
         1: nmi_n_out <= 1'b0;
         2: ep_out <= 1'b1;
         default: ip_out <= 1'b1;
      endcase
      repeat (3) @(posedge clk_in);
      {irq_n_out, nmi_n_out, ep_out, ip_out} <= 4'hC;
   endtask : wake
endmodule : core_pins_model
`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the low-power controller
// Assumes: Stabilisation count shortened to 16 cycles
// Notes: Partner model plays the core and the wake pins
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk, nrst, por, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, core_en, osc_en, tmr_en, adc_pwr, bus_rd, nmi_svc, set_masks;
   logic resume, cpu_rst, idle, stp, halt, gm, nm, ip, ep, irqn, nmin, stk;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0] r, rresp, bresp, br;
   logic [15:0] bus_addr, condition_code_register;
   int bad_count = 0, samples_checked = 0, resumes = 0, svcs = 0, masks = 0, i, n0;
   int stacks = 0;
   lpwr_ctrl #(.STAB_CYCLES(16)) DUT (.CORE_CLK_IN(clk), .NRST_IN(nrst), .POR_IN(por),
      .IDLE_OPCODE_IN(idle), .STOP_OPCODE_IN(stp), .HALT_BLOCK_FLAG_IN(halt),
      .GLOBAL_MASK_IN(gm), .NMI_MASK_IN(nm), .CCR_STACK_ADDR_IN(condition_code_register), .INT_PENDING_IN(ip),
      .IRQ_EDGE_PENDING_IN(ep), .IRQ_N_IN(irqn), .NMI_REQ_N_IN(nmin), .CORE_CLK_EN_OUT(core_en),
      .OSC_EN_OUT(osc_en), .TIMER_CLK_EN_OUT(tmr_en), .ADC_PWR_OUT(adc_pwr), .STACK_REQ_OUT(stk),
      .BUS_READ_OUT(bus_rd), .BUS_ADDR_OUT(bus_addr), .NMI_SERVICE_OUT(nmi_svc),
      .SET_MASKS_OUT(set_masks), .RESUME_OUT(resume), .CPU_RESET_OUT(cpu_rst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   core_pins_model core (.clk_in(clk), .masks_in(set_masks), .idle_out(idle), .stop_out(stp),
      .halt_out(halt), .gm_out(gm), .nm_out(nm), .addr_out(condition_code_register), .ip_out(ip), .ep_out(ep),
      .irq_n_out(irqn), .nmi_n_out(nmin));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Pulses are counted in each cycle they stand; a stack request stands 9 cycles per stack
   always @(posedge clk) begin
      if (resume === 1'b1) resumes++;
      if (nmi_svc === 1'b1) svcs++;
      if (set_masks === 1'b1) masks++;
      if (stk === 1'b1) stacks++;
   end
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat,
                         input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= dat;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      br = bresp;
      // Response is taken; release ready and let an edge pass
      bready <= 1'b0;
      @(posedge clk);
      if (n >= 50) chk(32'h0, 32'h1);
      if (n >= 50) test_done();
   endtask : axi_wr
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rsp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      dat = rdata;
      rsp = rresp;
      rready <= 1'b0;
      @(posedge clk);
      if (n >= 50) chk(32'h0, 32'h1);
      if (n >= 50) test_done();
   endtask : axi_rd
   // Polls the state field; bounded so a stuck state is logged as a mismatch
   task automatic wait_st(input logic [4:0] st);
      int n;
      n = 0;
      do begin
         axi_rd(4'h4, d, r);
         n++;
      end while (d[4:0] !== st && n < 60);
      chk({27'h0, d[4:0]}, {27'h0, st});
   endtask : wait_st
   initial begin
      {nrst, awvalid, wvalid, arvalid, por, bready, rready} = 7'h04;
      {awaddr, araddr, wdata, wstrb} = 44'h0000000000F;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      axi_rd(4'h4, d, r);
      chk(d, 32'h0000_0010);
      wait_st(5'h01);
      axi_rd(4'h0, d, r);
      chk(d, 32'h0000_0001);
      // Unmapped word answers with an error and zero data
      axi_rd(4'hC, d, r);
      chk({d[31:2], r}, 32'h0000_0002);
      axi_wr(4'h0, 32'h0000_0007);
      chk({30'h0, br}, 32'h0);
      @(posedge clk);
      chk({31'h0, adc_pwr}, 32'h1);
      axi_wr(4'h0, 32'h0000_0005);
      // Low byte lane off: control must keep its value
      axi_wr(4'h0, 32'h0000_0002, 4'hE);
      axi_rd(4'h0, d, r);
      chk(d, 32'h0000_0005);
      axi_wr(4'h8, 32'h0000_0000);
      chk({30'h0, br}, 32'h2);
      for (i = 0; i < 2; i++) begin
         core.flags(1'b0, i == 0, 1'b1);
         core.op(1'b0);
         wait_st(5'h04);
         chk({28'h0, core_en, osc_en, tmr_en, adc_pwr}, {28'h0, 2'b01, i[0], 1'b0});
         chk({15'h0, bus_rd, bus_addr}, 32'h0001_01F7);
         n0 = resumes;
         core.wake(3);
         wait_st(5'h01);
         chk(resumes - n0, 32'h1);
      end
      core.flags(1'b1, 1'b0, 1'b1);
      core.op(1'b1);
      repeat (2) @(posedge clk);
      axi_rd(4'h4, d, r);
      chk(d, 32'h0000_0001);
      core.flags(1'b0, 1'b1, 1'b1);
      core.op(1'b1);
      wait_st(5'h08);
      chk({29'h0, core_en, osc_en, tmr_en}, 32'h0);
      core.wake(0);
      axi_rd(4'h4, d, r);
      chk(d, 32'h0000_0008);
      core.flags(1'b0, 1'b0, 1'b1);
      n0 = resumes;
      core.wake(0);
      wait_st(5'h10);
      wait_st(5'h01);
      chk(resumes - n0, 32'h1);
      // Bypass: edge pending, masked and unmasked nonmaskable wakes
      axi_wr(4'h0, 32'h0000_0004);
      for (i = 0; i < 3; i++) begin
         core.flags(1'b0, i != 0, i != 2);
         core.op(1'b1);
         wait_st(5'h08);
         n0 = svcs;
         core.wake(i == 0 ? 2 : 1);
         axi_rd(4'h4, d, r);
         chk({27'h0, d[4:0]}, 32'h1);
         chk(svcs - n0, {31'h0, i == 2});
      end
      chk(masks, 32'h1);
      chk(stacks, 32'h12);
      core.flags(1'b0, 1'b1, 1'b1);
      core.op(1'b1);
      wait_st(5'h08);
      por <= 1'b0;
      nrst <= 1'b0;
      @(posedge clk);
      chk({30'h0, cpu_rst, osc_en}, 32'h3);
      nrst <= 1'b1;
      @(posedge clk);
      axi_rd(4'h4, d, r);
      chk(d, 32'h0000_0001);
      axi_rd(4'h0, d, r);
      chk(d, 32'h0000_0001);
      test_done();
   end
endmodule : testbench
`default_nettype wire
